// ---- logic/lss_slave.sv ----
`timescale 1ns/1ns
module lss_slave #(
    parameter int TIMEOUT_CYC = lss_pkg::TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic                          mclk,
    input  wire logic                          rst_b,
    // two-wire pins
    input  wire logic                          scl,
    input  wire logic                          sdaIn,
    output logic                               sdaOut,
    output logic                               sdaOeB,
    // straps
    input  wire logic [1:0]                    addrSel,
    input  wire logic                          smbusMode,
    // register file side
    output logic                               regWrEn,
    output logic [3:0]                         regAddr,
    output logic [7:0]                         regWrData,
    input  wire logic [7:0]                    regRdData,
    // converter side
    input  wire logic                          convDone,
    input  wire logic [lss_pkg::DATA_W-1:0]    ch0Raw,
    input  wire logic [lss_pkg::DATA_W-1:0]    ch1Raw,
    output logic                               integStart
);
    import lss_pkg::*;

    // slave address from the decoded pin level
    function automatic logic [6:0] slvAddr(input logic [1:0] sel);
        case (sel)
            SEL_GND:   slvAddr = ADDR_GND;
            SEL_FLOAT: slvAddr = ADDR_FLOAT;
            default:   slvAddr = ADDR_VDD;
        endcase
    endfunction : slvAddr

    logic [2:0]    sclS, sdaS;
    logic [1:0]    selS1, selS2;
    logic          smbS1, smbS2;
    lss_state_e    st_r, st_nxt;
    logic [2:0]    bitCnt_r, bitCnt_nxt;
    logic          full_r, full_nxt, rw_r, rw_nxt, nack_r, nack_nxt;
    logic          alert_r, alert_nxt, first_r, first_nxt;
    logic          blk_r, blk_nxt, skip_r, skip_nxt, oeB_r, oeB_nxt;
    logic [7:0]    shReg_r, shReg_nxt, txReg_r, txReg_nxt, wrData_r, wrData_nxt;
    logic [3:0]    ptr_r, ptr_nxt, cur_r, cur_nxt, wrAddr_r, wrAddr_nxt;
    logic          wrEn_r, wrEn_nxt;
    logic [TO_W-1:0] toCnt_r, toCnt_nxt;
    logic          sclRise, sclFall, startDet, stopDet, toHit, addrHit, cmdStb;
    logic          cntIns;
    logic [7:0]    rdByte;
    logic [DATA_W-1:0] data0, data1;
    logic [31:0]   dataAll;

    // pins and straps pass two flops before use
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sclS  <= 3'h7;
            sdaS  <= 3'h7;
            selS1 <= 2'h0;
            selS2 <= 2'h0;
            smbS1 <= 1'b0;
            smbS2 <= 1'b0;
        end else begin
            sclS  <= {sclS[1:0], scl};
            sdaS  <= {sdaS[1:0], sdaIn};
            selS1 <= addrSel;
            selS2 <= selS1;
            smbS1 <= smbusMode;
            smbS2 <= smbS1;
        end
    end

    // edges and bus conditions from the second and third stages
    assign sclRise  = sclS[1] && !sclS[2];
    assign sclFall  = !sclS[1] && sclS[2];
    assign startDet = sclS[1] && sclS[2] && !sdaS[1] && sdaS[2];
    assign stopDet  = sclS[1] && sclS[2] && sdaS[1] && !sdaS[2];
    assign toHit    = toCnt_r == TO_W'(TIMEOUT_CYC - 1);
    assign addrHit  = (shReg_r[7:1] == slvAddr(selS2))
                   || (shReg_r[7:1] == ADDR_ALERT);
    assign cmdStb   = (st_r == ST_WRB) && sclFall && full_r && first_r && shReg_r[CMD_FLAG_BIT];
    assign cntIns   = smbS2 && blk_r && (cur_r == PTR_ALL_DATA);
    assign dataAll  = {data1, data0};
    // pointer C..F reads the buffered results, the rest the register file
    assign rdByte   = (cur_r >= PTR_DATA_LO) ? dataAll[{cur_r[1:0], 3'h0} +: 8] : regRdData;

    // byte engine: shift on scl rise, drive on scl fall
    always_comb begin
        st_nxt     = st_r;
        bitCnt_nxt = bitCnt_r;
        full_nxt   = full_r;
        rw_nxt     = rw_r;
        nack_nxt   = nack_r;
        alert_nxt  = alert_r;
        first_nxt  = first_r;
        blk_nxt    = blk_r;
        skip_nxt   = skip_r;
        oeB_nxt    = oeB_r;
        shReg_nxt  = shReg_r;
        txReg_nxt  = txReg_r;
        ptr_nxt    = ptr_r;
        cur_nxt    = cur_r;
        wrAddr_nxt = wrAddr_r;
        wrData_nxt = wrData_r;
        wrEn_nxt   = 1'b0;
        // only smbus watches for a stuck bus; any clock edge restarts it, so long zero runs are not stuck
        toCnt_nxt  = (smbS2 && (!sclS[1] || !sdaS[1]) && !sclRise && !sclFall && !toHit) ? toCnt_r + TO_W'(1) : '0;
        if (toHit || stopDet) begin
            st_nxt  = ST_IDLE;
            oeB_nxt = 1'b1;
        end else if (startDet) begin
            st_nxt     = ST_ADDR;
            bitCnt_nxt = 3'h0;
            full_nxt   = 1'b0;
            oeB_nxt    = 1'b1;
        end else if (sclRise) begin
            case (st_r)
                ST_ADDR, ST_WRB: begin
                    shReg_nxt  = {shReg_r[6:0], sdaS[1]};
                    bitCnt_nxt = bitCnt_r + 3'h1;
                    full_nxt   = bitCnt_r == 3'h7;
                end
                ST_RDB: begin
                    bitCnt_nxt = bitCnt_r + 3'h1;
                    full_nxt   = bitCnt_r == 3'h7;
                end
                ST_RACK: nack_nxt = sdaS[1];
                default: ;
            endcase
        end else if (sclFall) begin
            case (st_r)
                ST_ADDR: if (full_r) begin
                    full_nxt = 1'b0;
                    if (addrHit) begin
                        st_nxt    = ST_AACK;
                        oeB_nxt   = 1'b0;
                        rw_nxt    = shReg_r[0];
                        alert_nxt = shReg_r[7:1] == ADDR_ALERT;
                        first_nxt = 1'b1;
                        skip_nxt  = 1'b0;
                        cur_nxt   = ptr_r;
                    end else begin
                        st_nxt = ST_IDLE;
                    end
                end
                ST_AACK: begin
                    bitCnt_nxt = 3'h0;
                    if (rw_r) begin
                        st_nxt = ST_RDB;
                        if (alert_r) begin
                            txReg_nxt = {slvAddr(selS2), 1'b0};
                        end else if (cntIns) begin
                            txReg_nxt = ALL_DATA_CNT;
                            cur_nxt   = PTR_DATA_LO;
                        end else begin
                            txReg_nxt = rdByte;
                            cur_nxt   = cur_r + 4'h1;
                        end
                        oeB_nxt = txReg_nxt[7];
                    end else begin
                        st_nxt  = ST_WRB;
                        oeB_nxt = 1'b1;
                    end
                end
                ST_WRB: if (full_r) begin
                    full_nxt  = 1'b0;
                    first_nxt = 1'b0;
                    st_nxt    = ST_WACK;
                    oeB_nxt   = 1'b0;
                    if (cmdStb) begin
                        ptr_nxt  = shReg_r[3:0];
                        cur_nxt  = shReg_r[3:0];
                        blk_nxt  = shReg_r[CMD_BLOCK_BIT];
                        skip_nxt = shReg_r[CMD_BLOCK_BIT] && smbS2;
                    end else if (skip_r) begin
                        skip_nxt = 1'b0;
                    end else begin
                        wrEn_nxt   = 1'b1;
                        wrAddr_nxt = cur_r;
                        wrData_nxt = shReg_r;
                        cur_nxt    = cur_r + 4'h1;
                    end
                end
                ST_WACK: begin
                    st_nxt     = ST_WRB;
                    oeB_nxt    = 1'b1;
                    bitCnt_nxt = 3'h0;
                end
                ST_RDB: if (full_r) begin
                    full_nxt = 1'b0;
                    st_nxt   = ST_RACK;
                    oeB_nxt  = 1'b1;
                end else begin
                    txReg_nxt = {txReg_r[6:0], 1'b1};
                    oeB_nxt   = txReg_r[6];
                end
                ST_RACK: begin
                    bitCnt_nxt = 3'h0;
                    if (nack_r) begin
                        st_nxt = ST_IDLE;
                    end else begin
                        st_nxt    = ST_RDB;
                        txReg_nxt = rdByte;
                        cur_nxt   = cur_r + 4'h1;
                        oeB_nxt   = rdByte[7];
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_r     <= ST_IDLE;
            bitCnt_r <= 3'h0;
            full_r   <= 1'b0;
            rw_r     <= 1'b0;
            nack_r   <= 1'b0;
            alert_r  <= 1'b0;
            first_r  <= 1'b0;
            blk_r    <= 1'b0;
            skip_r   <= 1'b0;
            oeB_r    <= 1'b1;
            shReg_r  <= 8'h00;
            txReg_r  <= 8'hFF;
            ptr_r    <= PTR_RESET;
            cur_r    <= PTR_RESET;
            wrAddr_r <= 4'h0;
            wrData_r <= 8'h00;
            wrEn_r   <= 1'b0;
            toCnt_r  <= '0;
        end else begin
            st_r     <= st_nxt;
            bitCnt_r <= bitCnt_nxt;
            full_r   <= full_nxt;
            rw_r     <= rw_nxt;
            nack_r   <= nack_nxt;
            alert_r  <= alert_nxt;
            first_r  <= first_nxt;
            blk_r    <= blk_nxt;
            skip_r   <= skip_nxt;
            oeB_r    <= oeB_nxt;
            shReg_r  <= shReg_nxt;
            txReg_r  <= txReg_nxt;
            ptr_r    <= ptr_nxt;
            cur_r    <= cur_nxt;
            wrAddr_r <= wrAddr_nxt;
            wrData_r <= wrData_nxt;
            wrEn_r   <= wrEn_nxt;
            toCnt_r  <= toCnt_nxt;
        end
    end

    // open drain: only ever pulls low
    assign sdaOut    = 1'b0;
    assign sdaOeB    = oeB_r;
    assign regWrEn   = wrEn_r;
    // read address follows the live pointer so regRdData is ready on the fall
    assign regAddr   = wrEn_r ? wrAddr_r : cur_r;
    assign regWrData = wrData_r;

    // results freeze for the whole transaction, so low and high bytes match
    lss_conv_buf #(
        .DW(DATA_W)
    ) u_conv (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .convDone  (convDone),
        .ch0Raw    (ch0Raw),
        .ch1Raw    (ch1Raw),
        .integStart(integStart),
        .holdOff   (st_r != ST_IDLE),
        .data0     (data0),
        .data1     (data1)
    );

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    property p_ack_own;
        st_r == ST_ADDR && st_nxt == ST_AACK |-> addrHit && !oeB_nxt;
    endproperty
    a_ack_own: assert property (p_ack_own) else $error("ack without address match");
    property p_alert;
        st_r == ST_ADDR && sclFall && full_r && shReg_r[7:1] == ADDR_ALERT && !toHit && !stopDet && !startDet
            |=> st_r == ST_AACK && alert_r;
    endproperty
    a_alert: assert property (p_alert) else $error("alert address not answered");
    property p_pin_addr;
        st_r == ST_ADDR && sclFall && full_r && shReg_r[7:1] == slvAddr(selS2) && !toHit && !stopDet
            && !startDet |=> st_r == ST_AACK && !oeB_r;
    endproperty
    a_pin_addr: assert property (p_pin_addr) else $error("own address not acked");
    property p_ptr_load;
        cmdStb && !toHit && !stopDet && !startDet |=> ptr_r == $past(shReg_r[3:0]) && !regWrEn;
    endproperty
    a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");
    property p_ptr_cause;
        !$stable(ptr_r) |-> $past(cmdStb);
    endproperty
    a_ptr_cause: assert property (p_ptr_cause) else $error("pointer changed without command");
    property p_skip_cnt;
        st_r == ST_WRB && sclFall && full_r && skip_r && !cmdStb |=> !regWrEn;
    endproperty
    a_skip_cnt: assert property (p_skip_cnt) else $error("byte count written");
    property p_cnt_ins;
        st_r == ST_AACK && sclFall && rw_r && !alert_r && cntIns && !toHit && !stopDet && !startDet
            |=> txReg_r == ALL_DATA_CNT && cur_r == PTR_DATA_LO;
    endproperty
    a_cnt_ins: assert property (p_cnt_ins) else $error("byte count not inserted");
    property p_nack_end;
        st_r == ST_RACK && sclFall && nack_r && !startDet |=> st_r == ST_IDLE ##1 oeB_r;
    endproperty
    a_nack_end: assert property (p_nack_end) else $error("read went on after nack");
    property p_timeout;
        toHit |=> st_r == ST_IDLE && oeB_r && toCnt_r == '0;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout did not abort");
    property p_rx_byte;
        st_r == ST_AACK && sclFall && rw_r && !alert_r && !cntIns && !toHit && !stopDet && !startDet
            |=> txReg_r == $past(rdByte) && cur_r == $past(cur_r) + 4'h1;
    endproperty
    a_rx_byte: assert property (p_rx_byte) else $error("read byte not from pointer");

    c_write: cover property (regWrEn);
    c_cmd: cover property (cmdStb);
    c_read: cover property (st_r == ST_RACK && sclFall && !nack_r);
    c_block: cover property (st_r == ST_AACK && sclFall && rw_r && cntIns);
endmodule : lss_slave

// ---- logic/lss_pkg.sv ----
// How it works
// - both channels integrate over one shared period
// - results reach data registers through double buffer
// - next integration starts right after each conversion
// - address pin level picks one of three addresses
// - alert response address always answered
// - first written byte with top bit set is command
// - command low nibble becomes register pointer
// - receive byte returns register at stored pointer
// - byte, word, block and combined transfers supported
// - block byte count ignored, bytes simply counted
// - read bytes continue until master sends nack
// - smbus read may follow address byte directly
// - smbus line held low too long aborts
// - send byte: address, one data byte, both acked
// - write byte: address, command, data, all acked
// - i2c write accepts data bytes until stop
// - pointer reads zero after power on
// - block read command 9Bh inserts count four
package lss_pkg;
    // address pin encoding after the three-level detector
    localparam logic [1:0] SEL_GND       = 2'h0;
    localparam logic [1:0] SEL_FLOAT     = 2'h1;
    localparam logic [1:0] SEL_VDD       = 2'h2;
    localparam logic [6:0] ADDR_GND      = 7'h29;
    localparam logic [6:0] ADDR_FLOAT    = 7'h39;
    localparam logic [6:0] ADDR_VDD      = 7'h49;
    localparam logic [6:0] ADDR_ALERT    = 7'h0C;
    // command byte layout
    localparam int         CMD_FLAG_BIT  = 7;
    localparam int         CMD_BLOCK_BIT = 4;
    localparam logic [3:0] PTR_RESET     = 4'h0;
    localparam logic [3:0] PTR_ALL_DATA  = 4'hB;
    localparam logic [3:0] PTR_DATA_LO   = 4'hC;
    localparam logic [7:0] ALL_DATA_CNT  = 8'h04;
    // bus low timeout, shortest legal value
    localparam int         TIMEOUT_MS    = 25;
    localparam int         CLK_MHZ       = 100;
    localparam int         TIMEOUT_CYC   = TIMEOUT_MS * CLK_MHZ * 1000;
    localparam int         TO_W          = 22;
    localparam int         DATA_W        = 16;
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_AACK = 7'h04,
        ST_WRB  = 7'h08,
        ST_WACK = 7'h10,
        ST_RDB  = 7'h20,
        ST_RACK = 7'h40
    } lss_state_e;
endpackage : lss_pkg

// ---- logic/lss_conv_buf.sv ----
`timescale 1ns/1ns
module lss_conv_buf #(
    parameter int DW = lss_pkg::DATA_W
) (
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          rst_b,
    // converter side
    input  wire logic          convDone,
    input  wire logic [DW-1:0] ch0Raw,
    input  wire logic [DW-1:0] ch1Raw,
    output logic               integStart,
    // bus side
    input  wire logic          holdOff,
    output logic [DW-1:0]      data0,
    output logic [DW-1:0]      data1
);
    import lss_pkg::*;
    logic [DW-1:0] shad0_r, shad0_nxt, shad1_r, shad1_nxt;
    logic [DW-1:0] vis0_r, vis0_nxt, vis1_r, vis1_nxt;
    logic          pend_r, pend_nxt, start_r, start_nxt, boot_r, boot_nxt;
    logic          xfer;

    // shadow takes both results at once, visible copy waits for an idle bus
    always_comb begin
        shad0_nxt = shad0_r;
        shad1_nxt = shad1_r;
        vis0_nxt  = vis0_r;
        vis1_nxt  = vis1_r;
        pend_nxt  = pend_r;
        boot_nxt  = 1'b1;
        xfer      = pend_r && !holdOff;
        start_nxt = !boot_r || convDone;
        if (xfer) begin
            vis0_nxt = shad0_r;
            vis1_nxt = shad1_r;
            pend_nxt = 1'b0;
        end
        if (convDone) begin
            shad0_nxt = ch0Raw;
            shad1_nxt = ch1Raw;
            pend_nxt  = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            shad0_r <= '0;
            shad1_r <= '0;
            vis0_r  <= '0;
            vis1_r  <= '0;
            pend_r  <= 1'b0;
            start_r <= 1'b0;
            boot_r  <= 1'b0;
        end else begin
            shad0_r <= shad0_nxt;
            shad1_r <= shad1_nxt;
            vis0_r  <= vis0_nxt;
            vis1_r  <= vis1_nxt;
            pend_r  <= pend_nxt;
            start_r <= start_nxt;
            boot_r  <= boot_nxt;
        end
    end

    // one start strobe feeds both converters, so periods match
    assign integStart = start_r;
    assign data0      = vis0_r;
    assign data1      = vis1_r;

    property p_hold_stable;
        @(posedge mclk) disable iff (!rst_b) holdOff |=> $stable(vis0_r) && $stable(vis1_r);
    endproperty
    a_hold_stable: assert property (p_hold_stable) else $error("data changed during bus hold");
    property p_restart;
        @(posedge mclk) disable iff (!rst_b) convDone |=> integStart;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart after conversion");
endmodule : lss_conv_buf

// ---- dv/lss_host_model.sv ----
`timescale 1ns/1ns
module lss_host_model (
    // reference clock, only used to keep pin changes off its edges
    input  wire logic mclk,
    // bus pins, open drain on data
    output logic      scl,
    output logic      sdaOeB,
    input  wire logic sda
);
    // idle bus: clock parked high, data left to the pull-up
    initial begin
        scl    = 1'b1;
        sdaOeB = 1'b1;
    end

    // one 125 ns bit, data changed only while the clock is low
    task automatic bit_io(input logic b, output logic s);
        scl = 1'b0;
        #20 sdaOeB = b;
        #40 scl = 1'b1;
        #30 s = sda;
        #35;
    endtask : bit_io

    // start or repeated start
    task automatic start_cond();
        // step off the sampling edge; all later steps are multiples of 5 ns
        @(posedge mclk);
        #2;
        scl = 1'b0;
        #20 sdaOeB = 1'b1;
        #40 scl = 1'b1;
        #65 sdaOeB = 1'b0;
        #60;
    endtask : start_cond

    // stop leaves both lines high
    task automatic stop_cond();
        scl = 1'b0;
        #20 sdaOeB = 1'b0;
        #40 scl = 1'b1;
        #65 sdaOeB = 1'b1;
        #60;
    endtask : stop_cond

    // byte out, msb first, then sample the acknowledge
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, ack);
    endtask : wr_byte

    // address byte always carries the direction bit
    task automatic addr(input logic [6:0] a, input logic rw, output logic ack);
        wr_byte({a, rw}, ack);
    endtask : addr

    // byte in; nack on the last one ends the read
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(last, s);
    endtask : rd_byte

    // stuck clock, to provoke the bus timeout
    task automatic hold_low(input int n);
        scl = 1'b0;
        #(n * 10);
    endtask : hold_low
endmodule : lss_host_model

// ---- dv/lss_slave_test.sv ----
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module lss_slave_test;
    import lss_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_b, scl, sdaIn, sdaOut, sdaOeB, hostOeB, smbusMode, regWrEn, convDone, integStart;
    logic [1:0]  addrSel;
    logic [3:0]  regAddr;
    logic [7:0]  regWrData, regRdData;
    logic [15:0] ch0Raw, ch1Raw;
    logic [7:0]  regFile [16];
    logic [6:0]  tab [3] = '{ADDR_GND, ADDR_FLOAT, ADDR_VDD};
    int          mismatches = 0;
    int          n_checks = 0;
    int          integCnt = 0;

    always #5 mclk = ~mclk;
    // wired-and data line with pull-up
    assign sdaIn = (sdaOeB | sdaOut) & hostOeB;
    // stand-in register file, read combinationally
    assign regRdData = regFile[regAddr];
    always @(posedge mclk) begin
        if (regWrEn === 1'b1) regFile[regAddr] <= regWrData;
        if (integStart === 1'b1) integCnt <= integCnt + 1;
    end

    lss_host_model u_host (.mclk(mclk), .scl(scl), .sdaOeB(hostOeB), .sda(sdaIn));
    lss_slave #(.TIMEOUT_CYC(200)) u_dut (
        .mclk(mclk), .rst_b(rst_b), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeB(sdaOeB),
        .addrSel(addrSel), .smbusMode(smbusMode), .regWrEn(regWrEn), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .convDone(convDone), .ch0Raw(ch0Raw),
        .ch1Raw(ch1Raw), .integStart(integStart));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    // whole write frame, every byte must be acknowledged
    task automatic wr_frame(input logic [7:0] b[$]);
        logic ack;
        u_host.start_cond();
        u_host.addr(ADDR_GND, 1'b0, ack);
        `CHK(ack, 1'b0)
        foreach (b[i]) begin
            u_host.wr_byte(b[i], ack);
            `CHK(ack, 1'b0)
        end
        u_host.stop_cond();
    endtask : wr_frame

    // read frame, optionally preceded by a command and repeated start
    task automatic rd_frame(input logic useCmd, input logic [6:0] a, input logic [7:0] cmd,
                            input logic [7:0] exp[$]);
        logic       ack;
        logic [7:0] d;
        u_host.start_cond();
        if (useCmd) begin
            u_host.addr(a, 1'b0, ack);
            u_host.wr_byte(cmd, ack);
            u_host.start_cond();
        end
        u_host.addr(a, 1'b1, ack);
        `CHK(ack, 1'b0)
        foreach (exp[i]) begin
            u_host.rd_byte(i == exp.size() - 1, d);
            `CHK(d, exp[i])
        end
        u_host.stop_cond();
    endtask : rd_frame

    // boot start pulse, then a receive byte from the reset pointer
    task automatic t_reset();
        `CHK(integCnt, 1)
        rd_frame(1'b0, ADDR_GND, 8'h00, '{8'h10});
        $display("test reset done");
    endtask : t_reset

    // each strap answers only its own address plus the alert address
    task automatic t_address();
        logic ack;
        for (int s = 0; s < 3; s++) begin
            @(posedge mclk);
            addrSel <= 2'(s);
            repeat (8) @(posedge mclk);
            for (int j = 0; j < 3; j++) begin
                u_host.start_cond();
                u_host.addr(tab[j], 1'b0, ack);
                u_host.stop_cond();
                `CHK(ack, (j == s) ? 1'b0 : 1'b1)
            end
            rd_frame(1'b0, ADDR_ALERT, 8'h00, '{{tab[s], 1'b0}});
        end
        @(posedge mclk);
        addrSel <= SEL_GND;
        repeat (8) @(posedge mclk);
        $display("test address done");
    endtask : t_address

    // write byte, streamed write, send byte and receive byte
    task automatic t_write();
        wr_frame('{8'h82, 8'h3C});
        `CHK(regFile[2], 8'h3C)
        wr_frame('{8'h85, 8'h11, 8'h22, 8'hA3});
        `CHK(regFile[5], 8'h11)
        `CHK(regFile[7], 8'hA3)
        wr_frame('{8'h83});
        rd_frame(1'b0, ADDR_GND, 8'h00, '{8'h13, 8'h14});
        $display("test write done");
    endtask : t_write

    // conversion hand-off, block write with bogus count, block read
    task automatic t_block();
        int n0;
        @(posedge mclk);
        smbusMode <= 1'b1;
        n0 = integCnt;
        @(posedge mclk);
        convDone <= 1'b1;
        ch0Raw   <= 16'h1234;
        ch1Raw   <= 16'h5678;
        @(posedge mclk);
        convDone <= 1'b0;
        repeat (3) @(posedge mclk);
        `CHK(integCnt, n0 + 1)
        wr_frame('{8'h92, 8'h07, 8'hA1, 8'hA2});
        `CHK(regFile[2], 8'hA1)
        `CHK(regFile[4], 8'h14)
        // a result that lands mid-read must wait until the bus is idle again
        fork
            rd_frame(1'b1, ADDR_GND, 8'h9B, '{8'h04, 8'h34, 8'h12, 8'h78, 8'h56});
            begin
                repeat (450) @(posedge mclk);
                convDone <= 1'b1;
                ch0Raw   <= 16'h9ABC;
                ch1Raw   <= 16'hDEF0;
                @(posedge mclk);
                convDone <= 1'b0;
            end
        join
        @(posedge mclk);
        smbusMode <= 1'b0;
        repeat (4) @(posedge mclk);
        rd_frame(1'b1, ADDR_GND, 8'h8E, '{8'hF0, 8'hDE, 8'h10});
        $display("test block done");
    endtask : t_block

    // clock stuck low past the limit abandons the transfer
    task automatic t_timeout();
        logic ack;
        @(posedge mclk);
        smbusMode <= 1'b1;
        repeat (4) @(posedge mclk);
        u_host.start_cond();
        u_host.addr(ADDR_GND, 1'b0, ack);
        u_host.hold_low(250);
        `CHK(sdaOeB, 1'b1)
        u_host.wr_byte(8'h83, ack);
        `CHK(ack, 1'b1)
        u_host.stop_cond();
        $display("test timeout done");
    endtask : t_timeout

    // whole run is well under half a millisecond
    initial begin
        #400000;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        rst_b     = 1'b0;
        addrSel   = SEL_GND;
        smbusMode = 1'b0;
        convDone  = 1'b0;
        ch0Raw    = 16'h0000;
        ch1Raw    = 16'h0000;
        for (int i = 0; i < 16; i++) regFile[i] = 8'h10 + 8'(i);
        repeat (6) @(posedge mclk);
        `CHK(sdaOeB, 1'b1)
        rst_b <= 1'b1;
        repeat (6) @(posedge mclk);
        t_reset();
        t_address();
        t_write();
        t_block();
        t_timeout();
        tally_and_finish();
    end
endmodule : lss_slave_test
